// *** verilog/sbt_defines.svh ***
// constants of the serial bit error test and receiver control block
// assumes inclusion by bare name from every design file of the block
`ifndef SBT_DEFINES_SVH
`define SBT_DEFINES_SVH

// register port geometry
`define SBT_ADDR_W 12
`define SBT_DATA_W 8
`define SBT_LANES 16
`define SBT_LANE_IDX_W 4

// register offsets (byte addresses)
`define SBT_OFS_TEST_CTRL 12'h1A0
`define SBT_OFS_LANE_BASE 12'h1B0
`define SBT_OFS_PHY_CTRL 12'h1C1
`define SBT_LANE_PAGE 8'h1B

// reset values
`define SBT_RST_TEST_CTRL 8'h00
`define SBT_RST_PHY_CTRL 8'h43
`define SBT_RST_BYTE 8'h00

// field positions
`define SBT_TEST_EN_BIT 0
`define SBT_LOSS_DET_BIT 0
`define SBT_OFFSET_CAL_BIT 1
`define SBT_CDR_LSB 4
`define SBT_CDR_MSB 6

// error counter limit
`define SBT_COUNT_MAX 8'hFF
`define SBT_COUNT_ONE 8'h01

// test pattern codes and shift register taps
`define SBT_PAT_PRBS7 2'h0
`define SBT_PAT_PRBS15 2'h1
`define SBT_PAT_PRBS31 2'h2
`define SBT_SHIFT_W 31
`define SBT_FILL_W 5
`define SBT_FILL_ONE 5'h01
`define SBT_ORDER_PRBS7 5'h07
`define SBT_ORDER_PRBS15 5'h0F
`define SBT_ORDER_PRBS31 5'h1F

// recovery loop table
`define SBT_SETTLE_W 11
`define SBT_SETTLE_SHORT_UI 11'h024
`define SBT_SETTLE_LONG_UI 11'h5F4
`define SBT_VOTE_15 4'hF
`define SBT_VOTE_7 4'h7
`define SBT_VOTE_3 4'h3
`define SBT_VOTE_1 4'h1
`define SBT_FIRST_ORDER_LO 3'h4

`endif

// *** verilog/sbt_pkg.sv ***
// types shared by the bit error test and receiver control block
// assumes sbt_defines.svh is reachable on the include path
`include "sbt_defines.svh"

package sbt_pkg;

    // one register port request, valid in the cycle it is presented
    typedef struct packed {
        logic [`SBT_ADDR_W-1:0] addr; // byte address
        logic [`SBT_DATA_W-1:0] wdata; // write data
        logic wr; // write strobe
        logic rd; // read strobe
    } sbt_bus_req_t;

    // recovery loop configuration shared by all lanes
    typedef struct packed {
        logic second_order; // loop tracks frequency offset
        logic [3:0] vote_threshold; // phase vote threshold
        logic [`SBT_SETTLE_W-1:0] settle_ui; // settling time in unit intervals
    } sbt_cdr_cfg_t;

endpackage

// *** verilog/sbt_cdr_decode.sv ***
// recovery loop setting decoder: three-bit setting to loop configuration
// assumes the caller registers the result; purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defines.svh"

module sbt_cdr_decode (
    // setting
    input wire logic [2:0] cdr_sel,
    // decoded configuration
    output sbt_pkg::sbt_cdr_cfg_t cdr_cfg
);

    // table lookup of order, vote threshold and settling time
    always_comb begin
        cdr_cfg.second_order = (cdr_sel < `SBT_FIRST_ORDER_LO);
        cdr_cfg.settle_ui = `SBT_SETTLE_SHORT_UI;
        case (cdr_sel)
            3'h0: cdr_cfg.vote_threshold = `SBT_VOTE_15;
            3'h1: cdr_cfg.vote_threshold = `SBT_VOTE_7;
            3'h2: cdr_cfg.vote_threshold = `SBT_VOTE_3;
            3'h3: cdr_cfg.vote_threshold = `SBT_VOTE_1;
            3'h4: cdr_cfg.vote_threshold = `SBT_VOTE_15;
            3'h5: cdr_cfg.vote_threshold = `SBT_VOTE_3;
            3'h6: cdr_cfg.vote_threshold = `SBT_VOTE_1;
            3'h7: begin
                // slowest setting also settles much longer
                cdr_cfg.vote_threshold = `SBT_VOTE_7;
                cdr_cfg.settle_ui = `SBT_SETTLE_LONG_UI;
            end
            default: cdr_cfg.vote_threshold = `SBT_VOTE_15;
        endcase
    end

endmodule
`default_nettype wire

// *** verilog/sbt_lane_checker.sv ***
// one lane of self-synchronising pseudo-random sequence checking
// assumes received bits arrive synchronous to sys_clk, one per valid cycle
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defines.svh"

module sbt_lane_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // control
    input wire logic enable,
    input wire logic restart,
    input wire logic [1:0] pattern_sel,
    // received data
    input wire logic rx_bit,
    input wire logic rx_valid,
    // result
    output logic [`SBT_DATA_W-1:0] err_count
);

    // all state of the lane
    typedef struct packed {
        logic [`SBT_SHIFT_W-1:0] shift; // last received bits
        logic [`SBT_FILL_W-1:0] fill; // bits taken since restart
        logic [`SBT_DATA_W-1:0] count; // saturating error count
    } sbt_lane_state_t;

    sbt_lane_state_t s_reg;
    sbt_lane_state_t s_next;

    // reference bit predicted from history for the chosen polynomial
    function automatic logic prbs_ref(input logic [`SBT_SHIFT_W-1:0] sh, input logic [1:0] sel);
        case (sel)
            `SBT_PAT_PRBS15: prbs_ref = sh[14] ^ sh[13];
            `SBT_PAT_PRBS31: prbs_ref = sh[30] ^ sh[27];
            default: prbs_ref = sh[6] ^ sh[5];
        endcase
    endfunction

    // history length needed before predictions are trusted
    function automatic logic [`SBT_FILL_W-1:0] prbs_order(input logic [1:0] sel);
        case (sel)
            `SBT_PAT_PRBS15: prbs_order = `SBT_ORDER_PRBS15;
            `SBT_PAT_PRBS31: prbs_order = `SBT_ORDER_PRBS31;
            default: prbs_order = `SBT_ORDER_PRBS7;
        endcase
    endfunction

    // next state: restart, lock, compare and count
    always_comb begin
        s_next = s_reg;
        if (restart) begin
            // clear and relock from received data only
            s_next = '0;
        end else if (enable && rx_valid) begin
            if (s_reg.fill < prbs_order(pattern_sel)) begin
                s_next.fill = s_reg.fill + `SBT_FILL_ONE;
            end else if ((rx_bit ^ prbs_ref(s_reg.shift, pattern_sel)) && (s_reg.count != `SBT_COUNT_MAX)) begin
                s_next.count = s_reg.count + `SBT_COUNT_ONE;
            end
            // history is fed from the line itself, no seed needed
            s_next.shift = {s_reg.shift[`SBT_SHIFT_W-2:0], rx_bit};
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign err_count = s_reg.count;

endmodule
`default_nettype wire

// *** verilog/sbt_top.sv ***
// bit error test and receiver control: register file, lane checkers, loop setup
// assumes a single sys_clk domain, lane bits synchronous to it, a register
// master that never strobes read and write together
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defines.svh"

module sbt_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire sbt_pkg::sbt_bus_req_t bus_req,
    output logic [`SBT_DATA_W-1:0] rd_data,
    // link context from the surrounding link logic
    input wire logic link_enable,
    input wire logic [1:0] link_test_pattern_select,
    // receive lanes
    input wire logic [`SBT_LANES-1:0] lane_rx_bit,
    input wire logic [`SBT_LANES-1:0] lane_rx_valid,
    // receiver physical layer controls
    output sbt_pkg::sbt_cdr_cfg_t cdr_cfg,
    output logic offset_cal_enable,
    output logic signal_loss_detect_enable,
    output logic bit_error_test_enable
);

    // all state of the top level
    typedef struct packed {
        logic [`SBT_DATA_W-1:0] test_ctrl; // bit error test control byte
        logic [`SBT_DATA_W-1:0] phy_ctrl; // receiver control byte
        logic [`SBT_DATA_W-1:0] rd_data; // read answer, one cycle only
        logic en_prev; // test enable last cycle
        logic restart; // one-cycle counter restart
        sbt_pkg::sbt_cdr_cfg_t cdr_cfg; // registered loop configuration
        logic cal_en; // registered offset calibration enable
        logic loss_en; // registered signal loss enable
        logic test_en; // registered test enable
    } sbt_top_state_t;

    sbt_top_state_t s_reg;
    sbt_top_state_t s_next;

    // decoded loop configuration for the current setting
    sbt_pkg::sbt_cdr_cfg_t cdr_dec;

    // per-lane error counts
    logic [`SBT_DATA_W-1:0] lane_count [`SBT_LANES];

    // current test enable bit as stored
    logic test_en_bit;

    // selected lane for a counter read
    logic [`SBT_LANE_IDX_W-1:0] lane_idx;

    // counter address on the register port, read strobe not decoded
    logic lane_hit;

    // true when an address falls in the lane counter page
    function automatic logic is_lane_addr(input logic [`SBT_ADDR_W-1:0] a);
        is_lane_addr = (a[`SBT_ADDR_W-1:`SBT_LANE_IDX_W] == `SBT_LANE_PAGE);
    endfunction

    // test enable bit straight from its byte
    assign test_en_bit = s_reg.test_ctrl[`SBT_TEST_EN_BIT];

    // lane index is the low address nibble, lane 0 lowest
    assign lane_idx = bus_req.addr[`SBT_LANE_IDX_W-1:0];

    // counter page decode
    assign lane_hit = is_lane_addr(bus_req.addr);

    // recovery setting table
    sbt_cdr_decode u_cdr_decode (
        .cdr_sel(s_reg.phy_ctrl[`SBT_CDR_MSB:`SBT_CDR_LSB]),
        .cdr_cfg(cdr_dec)
    );

    // one checker per receive lane
    genvar g;
    generate
        for (g = 0; g < `SBT_LANES; g++) begin : g_lane
            sbt_lane_checker u_lane (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .enable(s_reg.test_en),
                .restart(s_reg.restart),
                .pattern_sel(link_test_pattern_select),
                .rx_bit(lane_rx_bit[g]),
                .rx_valid(lane_rx_valid[g]),
                .err_count(lane_count[g])
            );
        end
    endgenerate

    // next state: register writes, read answers, enable edge, output copies
    always_comb begin
        s_next = s_reg;

        // read data stand only in the cycle after the strobe
        s_next.rd_data = `SBT_RST_BYTE;

        // register writes; counters are read only
        if (bus_req.wr) begin
            case (bus_req.addr)
                `SBT_OFS_TEST_CTRL: begin
                    // whole byte kept, reserved bits read back
                    s_next.test_ctrl = bus_req.wdata;
                end
                `SBT_OFS_PHY_CTRL: begin
                    // takes effect at once; safe use is while unlinked
                    s_next.phy_ctrl = bus_req.wdata;
                end
                default: begin
                    // unmapped or read-only address: ignored
                    s_next.test_ctrl = s_reg.test_ctrl;
                end
            endcase
        end

        // register reads
        if (bus_req.rd) begin
            if (lane_hit) begin
                // one counter per byte address
                s_next.rd_data = lane_count[lane_idx];
            end else begin
                case (bus_req.addr)
                    `SBT_OFS_TEST_CTRL: begin
                        s_next.rd_data = s_reg.test_ctrl;
                    end
                    `SBT_OFS_PHY_CTRL: begin
                        s_next.rd_data = s_reg.phy_ctrl;
                    end
                    default: begin
                        // unmapped address reads zero
                        s_next.rd_data = `SBT_RST_BYTE;
                    end
                endcase
            end
        end

        // rising edge of the stored enable restarts every lane
        s_next.en_prev = test_en_bit;
        s_next.restart = test_en_bit && !s_reg.en_prev;

        // counting follows the enable bit, held off on the restart cycle
        s_next.test_en = test_en_bit;

        // loop settings for all lanes
        s_next.cdr_cfg = cdr_dec;

        // calibration and signal loss enables for all lanes
        s_next.cal_en = s_reg.phy_ctrl[`SBT_OFFSET_CAL_BIT];
        s_next.loss_en = s_reg.phy_ctrl[`SBT_LOSS_DET_BIT];
    end

    // state register with synchronous reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_reg.test_ctrl <= `SBT_RST_TEST_CTRL;
            // recovery setting 100b, calibration and loss detect on
            s_reg.phy_ctrl <= `SBT_RST_PHY_CTRL;
            s_reg.rd_data <= `SBT_RST_BYTE;
            s_reg.en_prev <= 1'b0;
            s_reg.restart <= 1'b0;
            // reset copy of setting 100b: first order, threshold 15
            s_reg.cdr_cfg.second_order <= 1'b0;
            s_reg.cdr_cfg.vote_threshold <= `SBT_VOTE_15;
            s_reg.cdr_cfg.settle_ui <= `SBT_SETTLE_SHORT_UI;
            s_reg.cal_en <= 1'b1;
            s_reg.loss_en <= 1'b1;
            s_reg.test_en <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from state flip-flops
    assign rd_data = s_reg.rd_data;
    assign cdr_cfg = s_reg.cdr_cfg;
    assign offset_cal_enable = s_reg.cal_en;
    assign signal_loss_detect_enable = s_reg.loss_en;
    assign bit_error_test_enable = s_reg.test_en;

    // link_enable is context only: the ordering of setup against it is
    // the host's duty and nothing here blocks writes on it
    logic link_enable_unused;
    assign link_enable_unused = link_enable;

endmodule
`default_nettype wire

// *** tb/sbt_prbs_tx.sv ***
// partner model: far-end transmitter sending one pseudo-random stream on all lanes
// assumes the bench drives run, pattern_sel and flip by non-blocking assignment at sys_clk
`timescale 1ns/100ps
`default_nettype none

module sbt_prbs_tx (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // control from the bench
    input wire logic run,
    input wire logic [1:0] pattern_sel,
    input wire logic [15:0] flip,
    // lane outputs
    output logic [15:0] lane_bit,
    output logic [15:0] lane_valid
);
    logic [30:0] shift_reg; // last bits sent, bit 0 newest
    logic tog_reg; // changing filler while the lanes are idle
    logic next_bit; // recurrence of the selected polynomial

    // 0: x^7+x^6+1, 1: x^15+x^14+1, otherwise x^31+x^28+1
    always_comb begin
        case (pattern_sel)
            2'h0: next_bit = shift_reg[6] ^ shift_reg[5];
            2'h1: next_bit = shift_reg[14] ^ shift_reg[13];
            default: next_bit = shift_reg[30] ^ shift_reg[27];
        endcase
    end

    // advance the sequence only while sending
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shift_reg <= 31'h7FFFFFFF;
            tog_reg <= 1'b0;
        end else begin
            tog_reg <= !tog_reg;
            if (run) begin
                shift_reg <= {shift_reg[29:0], next_bit};
            end
        end
    end

    // every lane is valid exactly while run is high, so no count is undefined
    assign lane_valid = {16{run}};
    // flip inverts chosen lanes without disturbing the sequence
    assign lane_bit = run ? ({16{next_bit}} ^ flip) : {16{tog_reg}};
endmodule

`default_nettype wire

// *** tb/sbt_top_chk.sv ***
// checker of the register and phy control ports of the top module
// assumes sbt_defines.svh on the include path and one sys_clk domain
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defines.svh"

module sbt_top_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire sbt_pkg::sbt_bus_req_t bus_req,
    input wire logic [`SBT_DATA_W-1:0] rd_data,
    // phy controls
    input wire sbt_pkg::sbt_cdr_cfg_t cdr_cfg,
    input wire logic offset_cal_enable,
    input wire logic signal_loss_detect_enable,
    input wire logic bit_error_test_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic ctrl_wr; // write to the test control register
    logic phy_wr; // write to the receiver control register
    assign ctrl_wr = bus_req.wr && (bus_req.addr == `SBT_OFS_TEST_CTRL);
    assign phy_wr = bus_req.wr && (bus_req.addr == `SBT_OFS_PHY_CTRL);

    // write taken, then two cycles until the output follows
    sequence s_ctrl_wr;
        ctrl_wr ##2 1'b1;
    endsequence
    sequence s_phy_wr;
        phy_wr ##2 1'b1;
    endsequence

    // vote threshold of every recovery setting
    function automatic logic [3:0] vote_of(input logic [2:0] s);
        case (s)
            3'h0, 3'h4: vote_of = 4'hF;
            3'h1, 3'h7: vote_of = 4'h7;
            3'h2, 3'h5: vote_of = 4'h3;
            default: vote_of = 4'h1;
        endcase
    endfunction

    chk_rd_idle_zero: assert property (!bus_req.rd |=> rd_data == 8'h00)
        else $error("read data not zero outside read answer");
    chk_test_en_follow: assert property (s_ctrl_wr |-> bit_error_test_enable == $past(bus_req.wdata[0], 2))
        else $error("test enable does not follow write");
    chk_test_en_hold: assert property (!ctrl_wr |-> ##2 $stable(bit_error_test_enable))
        else $error("test enable changed without write");
    chk_oc_follow: assert property (s_phy_wr |-> offset_cal_enable == $past(bus_req.wdata[1], 2))
        else $error("offset calibration enable wrong");
    chk_los_follow: assert property (s_phy_wr |-> signal_loss_detect_enable == $past(bus_req.wdata[0], 2))
        else $error("signal loss enable wrong");
    chk_cdr_order: assert property (s_phy_wr |-> cdr_cfg.second_order == !$past(bus_req.wdata[6], 2))
        else $error("loop order wrong");
    chk_cdr_settle: assert property (s_phy_wr |->
        cdr_cfg.settle_ui == (($past(bus_req.wdata[6:4], 2) == 3'h7) ? 11'h5F4 : 11'h024))
        else $error("settling time wrong");
    chk_cdr_vote: assert property (s_phy_wr |->
        cdr_cfg.vote_threshold == vote_of($past(bus_req.wdata[6:4], 2)))
        else $error("vote threshold wrong");
    chk_cdr_hold: assert property (!phy_wr |-> ##2 $stable(cdr_cfg))
        else $error("loop setting changed without write");
    chk_reset_vals: assert property ($rose(rst_n) |-> cdr_cfg == {1'b0, 4'hF, 11'h024} && offset_cal_enable
        && signal_loss_detect_enable && !bit_error_test_enable)
        else $error("phy controls wrong after reset");
endmodule

bind sbt_top sbt_top_chk u_chk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .cdr_cfg(cdr_cfg),
    .offset_cal_enable(offset_cal_enable),
    .signal_loss_detect_enable(signal_loss_detect_enable),
    .bit_error_test_enable(bit_error_test_enable)
);

`default_nettype wire

// *** tb/serdes_ber_test_and_phy_ctrl_bench.sv ***
// self-checking bench of the bit error test block with a prbs7, prbs15 and prbs31 partner
// assumes the design files and sbt_defines.svh are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defines.svh"

module serdes_ber_test_and_phy_ctrl_bench;
    typedef struct packed {
        logic [7:0] wdata; // value written to receiver control
        sbt_pkg::sbt_cdr_cfg_t cfg; // configuration it should give
    } sbt_row_t;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    sbt_pkg::sbt_bus_req_t bus_req = '0;
    logic [7:0] rd_data;
    logic link_enable = 1'b0;
    logic [1:0] pat_sel = 2'h0; // pattern sent and checked, prbs7 first
    logic run = 1'b0;
    logic [15:0] flip = 16'h0000;
    logic [15:0] lane_bit;
    logic [15:0] lane_valid;
    sbt_pkg::sbt_cdr_cfg_t cdr_cfg;
    logic cal_en;
    logic loss_en;
    logic test_en;
    int n_fail = 0;
    int comparisons = 0;
    sbt_row_t rows [8];

    always #5 sys_clk = !sys_clk;

    sbt_prbs_tx u_tx (.sys_clk(sys_clk), .rst_n(rst_n), .run(run), .pattern_sel(pat_sel), .flip(flip),
        .lane_bit(lane_bit), .lane_valid(lane_valid));

    sbt_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
        .link_enable(link_enable), .link_test_pattern_select(pat_sel), .lane_rx_bit(lane_bit),
        .lane_rx_valid(lane_valid), .cdr_cfg(cdr_cfg), .offset_cal_enable(cal_en),
        .signal_loss_detect_enable(loss_en), .bit_error_test_enable(test_en));

    task automatic give_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cfg(input sbt_pkg::sbt_cdr_cfg_t got, input sbt_pkg::sbt_cdr_cfg_t exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: loop cfg %h expected %h", $time, got, exp);
        end
    endtask

    // let n edges pass and settle
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one-cycle write strobe
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask

    // one-cycle read strobe, data checked in the following cycle
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk8(rd_data, exp);
    endtask

    task automatic set_flip(input logic [15:0] m);
        @(posedge sys_clk);
        flip <= m;
    endtask

    // reset for three edges, released on an edge, one edge let pass
    task automatic do_reset;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        cyc(1);
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        give_verdict();
    end

    initial begin
        rows = '{{8'h01, 1'b1, 4'hF, 11'h024}, {8'h12, 1'b1, 4'h7, 11'h024}, {8'h23, 1'b1, 4'h3, 11'h024},
            {8'h30, 1'b1, 4'h1, 11'h024}, {8'h42, 1'b0, 4'hF, 11'h024}, {8'h51, 1'b0, 4'h3, 11'h024},
            {8'h60, 1'b0, 4'h1, 11'h024}, {8'hF3, 1'b0, 4'h7, 11'h5F4}};
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        // every loop setting, link held off while configuring
        for (int i = 0; i < 8; i++) begin
            wr_reg(`SBT_OFS_PHY_CTRL, rows[i].wdata);
            cyc(2);
            chk_cfg(cdr_cfg, rows[i].cfg);
            chk8({7'h00, cal_en}, {7'h00, rows[i].wdata[1]});
            chk8({7'h00, loss_en}, {7'h00, rows[i].wdata[0]});
            rd_chk(`SBT_OFS_PHY_CTRL, rows[i].wdata);
        end
        $display("done: loop settings");
        // second reset in mid-run restores defaults
        do_reset();
        chk_cfg(cdr_cfg, {1'b0, 4'hF, 11'h024});
        chk8({6'h00, cal_en, loss_en}, 8'h03);
        chk8({7'h00, test_en}, 8'h00);
        rd_chk(`SBT_OFS_PHY_CTRL, 8'h43);
        rd_chk(`SBT_OFS_TEST_CTRL, 8'h00);
        rd_chk(12'h000, 8'h00);
        $display("done: reset values");
        // errors while the test is off are not counted
        @(posedge sys_clk);
        run <= 1'b1;
        set_flip(16'h0020);
        cyc(50);
        set_flip(16'h0000);
        rd_chk(`SBT_OFS_LANE_BASE + 12'h005, 8'h00);
        @(posedge sys_clk);
        link_enable <= 1'b1;
        wr_reg(`SBT_OFS_TEST_CTRL, 8'h01);
        cyc(100);
        chk8({7'h00, test_en}, 8'h01);
        set_flip(16'h0008);
        set_flip(16'h0000);
        cyc(20);
        for (int i = 0; i < 16; i++) begin
            rd_chk(`SBT_OFS_LANE_BASE + 12'(i), (i == 3) ? 8'h03 : 8'h00);
        end
        $display("done: single error");
        // disabled: counts held, new errors ignored
        wr_reg(`SBT_OFS_TEST_CTRL, 8'h00);
        set_flip(16'h0020);
        cyc(20);
        set_flip(16'h0000);
        rd_chk(`SBT_OFS_LANE_BASE + 12'h003, 8'h03);
        rd_chk(`SBT_OFS_LANE_BASE + 12'h005, 8'h00);
        wr_reg(`SBT_OFS_TEST_CTRL, 8'h01);
        cyc(5);
        rd_chk(`SBT_OFS_LANE_BASE + 12'h003, 8'h00);
        $display("done: restart");
        // every bit wrong drives the count to its ceiling
        set_flip(16'h0020);
        cyc(400);
        set_flip(16'h0000);
        cyc(20);
        rd_chk(`SBT_OFS_LANE_BASE + 12'h005, 8'hFF);
        wr_reg(`SBT_OFS_LANE_BASE + 12'h005, 8'h00);
        rd_chk(`SBT_OFS_LANE_BASE + 12'h005, 8'hFF);
        rd_chk(`SBT_OFS_LANE_BASE + 12'h000, 8'h00);
        rd_chk(`SBT_OFS_TEST_CTRL, 8'h01);
        $display("done: saturation");
        // the longer polynomials relock after restart and count one line error
        for (int p = 1; p < 3; p++) begin
            wr_reg(`SBT_OFS_TEST_CTRL, 8'h00);
            @(posedge sys_clk);
            pat_sel <= 2'(p);
            wr_reg(`SBT_OFS_TEST_CTRL, 8'h01);
            cyc(100);
            rd_chk(`SBT_OFS_LANE_BASE + 12'h005, 8'h00);
            set_flip(16'h0400);
            set_flip(16'h0000);
            cyc(40);
            rd_chk(`SBT_OFS_LANE_BASE + 12'h00A, 8'h03);
        end
        $display("done: other patterns");
        // reset also clears the counters and the test enable
        do_reset();
        rd_chk(`SBT_OFS_LANE_BASE + 12'h00A, 8'h00);
        rd_chk(`SBT_OFS_TEST_CTRL, 8'h00);
        $display("done: reset clears counts");
        give_verdict();
    end
endmodule

`default_nettype wire
